// file: smsc_defines.vh
// Purpose: Shared constants of the status output and monitor scaler.
// Assumes: APB word registers, 0.1 percent units for gain, bias and monitor values.
// Notes: Analog codes are in 0.1 percent of full scale, so 1000 is 10 V or 20 mA.
`ifndef SMSC_DEFINES_VH
`define SMSC_DEFINES_VH

// Register byte offsets.
`define SMSC_OFS_FIRST_ITEM 8'h00
`define SMSC_OFS_FIRST_GAIN 8'h04
`define SMSC_OFS_FIRST_BIAS 8'h08
`define SMSC_OFS_SECOND_ITEM 8'h0C
`define SMSC_OFS_SECOND_GAIN 8'h10
`define SMSC_OFS_SECOND_BIAS 8'h14
`define SMSC_OFS_FIRST_LEVEL 8'h18
`define SMSC_OFS_SECOND_LEVEL 8'h1C
`define SMSC_OFS_CONTACT0 8'h20
`define SMSC_OFS_CONTACT1 8'h24
`define SMSC_OFS_CONTACT2 8'h28
`define SMSC_OFS_INT_STATUS 8'h2C
`define SMSC_OFS_INT_MASK 8'h30
`define SMSC_OFS_STATE 8'h34
`define SMSC_OFS_OUT_ONE 8'h38
`define SMSC_OFS_OUT_TWO 8'h3C

// Reset values.
`define SMSC_RST_FIRST_ITEM 16'h0002
`define SMSC_RST_SECOND_ITEM 16'h0003
`define SMSC_RST_FIRST_GAIN 16'h03E8
`define SMSC_RST_SECOND_GAIN 16'h01F4
`define SMSC_RST_BIAS 16'h0000
`define SMSC_RST_LEVEL 2'h0
`define SMSC_RST_CONTACT0 8'h00
`define SMSC_RST_CONTACT1 8'h01
`define SMSC_RST_CONTACT2 8'h02

// Setting limits; gain and bias in 0.1 percent, item as a monitor number.
`define SMSC_GAIN_MAX 16'h2710
`define SMSC_BIAS_LIM 16'h044C
`define SMSC_ITEM_MAX 16'h0026

// Level selector codes.
`define SMSC_LVL_UNI 2'h0
`define SMSC_LVL_BIP 2'h1
`define SMSC_LVL_CUR 2'h2

// Scaling constants in 0.1 percent of full scale.
`define SMSC_FULL_SCALE 12'h3E8
`define SMSC_CUR_ZERO 12'h0C8

// Contact function codes.
`define SMSC_FN_RUN_SRC 8'h0A
`define SMSC_FN_FAULT 8'h0E
`define SMSC_FN_MINOR 8'h10
`define SMSC_FN_FAULT_RST 8'h11
`define SMSC_FN_REVERSE 8'h1A
`define SMSC_FN_BLOCK2 8'h1B
`define SMSC_FN_MOTOR2 8'h1C
`define SMSC_FN_RUN2 8'h37
`define SMSC_FN_DRV_EN 8'h38

// Interrupt status bit positions.
`define SMSC_INT_FAULT 0
`define SMSC_INT_MINOR 1
`define SMSC_INT_SAT_ONE 2
`define SMSC_INT_SAT_TWO 3
`define SMSC_INT_REJECT 4
`define SMSC_INT_W 5

`endif

// file: smsc_scaler.v
// Purpose: Combinational gain, bias, clamp and range mapping of one monitor value.
// Assumes: Value, gain and bias in 0.1 percent; gain and bias already range checked.
// Notes: Output code in 0.1 percent of full scale, signed, range -1000 to 1000.
`timescale 1ns/100ps
`include "smsc_defines.vh"
module smsc_scaler (
    // Monitor sample and settings.
    input wire signed [15:0] item_value,
    input wire [15:0] gain,
    input wire signed [15:0] bias,
    input wire [1:0] level,
    // Scaled result.
    output reg signed [11:0] code,
    output reg saturated
);

    localparam signed [35:0] PCT_SCALE = 36'sd1000;

    reg signed [35:0] slope;
    reg signed [35:0] raw;
    reg signed [35:0] lo;
    reg signed [35:0] hi;
    reg signed [35:0] clip;

    always @* begin
        // Output is bias at 0 percent of the item and gain at 100 percent.
        // Every operand is signed so that negative items divide toward zero.
        slope = $signed({20'h00000, gain}) - $signed({{20{bias[15]}}, bias});
        raw = $signed({{20{bias[15]}}, bias})
            + ($signed({{20{item_value[15]}}, item_value}) * slope) / PCT_SCALE;
        hi = {24'h000000, `SMSC_FULL_SCALE};
        lo = (level == `SMSC_LVL_BIP) ? -hi : 36'sd0;
        saturated = (raw > hi) || (raw < lo);
        if (raw > hi) begin
            clip = hi;
        end else if (raw < lo) begin
            clip = lo;
        end else begin
            clip = raw;
        end
        if (level == `SMSC_LVL_CUR) begin
            // Zero maps to 4 mA and full scale to 20 mA.
            code = `SMSC_CUR_ZERO + clip[11:0] - clip[11:0] / 12'sd5;
        end else begin
            code = clip[11:0];
        end
    end

endmodule // smsc_scaler

// file: smsc_top.v
// Purpose: Contact status outputs and two scaled analog monitor channels behind APB.
// Assumes: Drive status inputs are asynchronous; the monitor lookup shares pclk.
// Notes: The two analog channels share one scaler and are refreshed on alternate cycles.
// Operation
// - Code A: on while keypad is run source
// - Code E: major faults except two excluded
// - Code 10: on while minor fault present
// - Code 11: on while fault reset requested
// - Code 1A: on during reverse run request
// - Code 1B: off while blocking request asserted
// - Code 1C: on while motor two selected
// - Code 37: on while frequency is output
// - Code 38: on while drive enabled
// - Item select accepts only valid monitor numbers
// - Gain 0 to 1000.0 percent, defaults 100/50
// - Bias -110.0 to +110.0 percent, default zero
// - Analog output saturates at full scale
// - Bipolar mode keeps sign of value
`timescale 1ns/100ps
`include "smsc_defines.vh"
module smsc_top #(
    parameter NUM_CONTACTS = 3
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Drive status, asynchronous levels.
    input wire run_src_keypad,
    input wire major_fault,
    input wire excluded_fault_a,
    input wire excluded_fault_b,
    input wire minor_fault,
    input wire fault_reset_req,
    input wire reverse_run_req,
    input wire block_req,
    input wire motor_two_sel,
    input wire freq_output_on,
    input wire drive_enable_req,
    // Status monitor group lookup.
    output reg [5:0] monitor_item,
    input wire [15:0] monitor_value,
    // Contact and analog outputs.
    output reg [NUM_CONTACTS-1:0] contact_out,
    output reg [11:0] analog_out_one,
    output reg [1:0] analog_out_one_range,
    output reg [11:0] analog_out_two,
    output reg [1:0] analog_out_two_range,
    // Interrupt.
    output reg irq
);

    localparam NSTAT = 11;
    localparam S_KEYPAD = 0;
    localparam S_FAULT = 1;
    localparam S_EXC_A = 2;
    localparam S_EXC_B = 3;
    localparam S_MINOR = 4;
    localparam S_FRST = 5;
    localparam S_REV = 6;
    localparam S_BLOCK = 7;
    localparam S_MOT2 = 8;
    localparam S_FREQ = 9;
    localparam S_DRVEN = 10;
    // The lookup port is only six bits wide, so the reset item is cut on purpose.
    localparam [15:0] FIRST_ITEM_RST = `SMSC_RST_FIRST_ITEM;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Monitor numbers 4, 10 to 14, 28 and 34 have no analog meaning.
    function item_ok;
        input [15:0] v;
        begin
            item_ok = (v >= 16'h0001) && (v <= `SMSC_ITEM_MAX) && (v != 16'h0004)
                && !((v >= 16'h000A) && (v <= 16'h000E))
                && (v != 16'h001C) && (v != 16'h0022);
        end
    endfunction

    function gain_ok;
        input [15:0] v;
        begin
            gain_ok = (v <= `SMSC_GAIN_MAX);
        end
    endfunction

    function bias_ok;
        input [15:0] v;
        begin
            bias_ok = ($signed(v) <= $signed(`SMSC_BIAS_LIM))
                && ($signed(v) >= -$signed(`SMSC_BIAS_LIM));
        end
    endfunction

    function level_ok;
        input [15:0] v;
        begin
            level_ok = (v <= {14'h0000, `SMSC_LVL_CUR});
        end
    endfunction

    // Contact function decode; unknown codes leave the contact open.
    function contact_fn;
        input [7:0] code;
        input [NSTAT-1:0] s;
        begin
            case (code)
                `SMSC_FN_RUN_SRC: contact_fn = s[S_KEYPAD];
                `SMSC_FN_FAULT: contact_fn = s[S_FAULT] & ~s[S_EXC_A] & ~s[S_EXC_B];
                `SMSC_FN_MINOR: contact_fn = s[S_MINOR];
                `SMSC_FN_FAULT_RST: contact_fn = s[S_FRST];
                `SMSC_FN_REVERSE: contact_fn = s[S_REV];
                `SMSC_FN_BLOCK2: contact_fn = ~s[S_BLOCK];
                `SMSC_FN_MOTOR2: contact_fn = s[S_MOT2];
                `SMSC_FN_RUN2: contact_fn = s[S_FREQ];
                `SMSC_FN_DRV_EN: contact_fn = s[S_DRVEN];
                default: contact_fn = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    reg [NSTAT-1:0] sync1_q;
    reg [NSTAT-1:0] stat_q;
    reg [NSTAT-1:0] stat_prev_q;
    wire [NSTAT-1:0] stat_raw;

    assign stat_raw = {drive_enable_req, freq_output_on, motor_two_sel, block_req,
                       reverse_run_req, fault_reset_req, minor_fault, excluded_fault_b,
                       excluded_fault_a, major_fault, run_src_keypad};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= {NSTAT{1'b0}};
            stat_q <= {NSTAT{1'b0}};
            stat_prev_q <= {NSTAT{1'b0}};
        end else begin
            sync1_q <= stat_raw;
            stat_q <= sync1_q;
            stat_prev_q <= stat_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Settings registers.

    reg [15:0] item_q [0:1];
    reg [15:0] gain_q [0:1];
    reg [15:0] bias_q [0:1];
    reg [1:0] level_q [0:1];
    reg [7:0] csel_q [0:NUM_CONTACTS-1];
    reg [`SMSC_INT_W-1:0] int_status_q;
    reg [`SMSC_INT_W-1:0] int_mask_q;
    reg [`SMSC_INT_W-1:0] int_status_d;
    reg [`SMSC_INT_W-1:0] events;
    reg reject_d;
    wire wr_en;
    wire setup;
    wire [15:0] wv;
    wire sat;
    wire signed [11:0] scaled;
    reg chan_q;
    integer i;

    // Writes take effect in the access phase; pready is low in reset and high from the first clock after it.
    assign wr_en = psel & penable & pwrite;
    assign setup = psel & ~penable;
    assign wv = pwdata[15:0];

    // Out-of-range settings are refused and keep the previous value.
    always @* begin
        reject_d = 1'b0;
        if (wr_en) begin
            case (paddr)
                `SMSC_OFS_FIRST_ITEM, `SMSC_OFS_SECOND_ITEM: reject_d = !item_ok(wv);
                `SMSC_OFS_FIRST_GAIN, `SMSC_OFS_SECOND_GAIN: reject_d = !gain_ok(wv);
                `SMSC_OFS_FIRST_BIAS, `SMSC_OFS_SECOND_BIAS: reject_d = !bias_ok(wv);
                `SMSC_OFS_FIRST_LEVEL, `SMSC_OFS_SECOND_LEVEL: reject_d = !level_ok(wv);
                default: reject_d = 1'b0;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            item_q[0] <= `SMSC_RST_FIRST_ITEM;
            item_q[1] <= `SMSC_RST_SECOND_ITEM;
            gain_q[0] <= `SMSC_RST_FIRST_GAIN;
            gain_q[1] <= `SMSC_RST_SECOND_GAIN;
            bias_q[0] <= `SMSC_RST_BIAS;
            bias_q[1] <= `SMSC_RST_BIAS;
            level_q[0] <= `SMSC_RST_LEVEL;
            level_q[1] <= `SMSC_RST_LEVEL;
            csel_q[0] <= `SMSC_RST_CONTACT0;
            csel_q[1] <= `SMSC_RST_CONTACT1;
            csel_q[2] <= `SMSC_RST_CONTACT2;
            int_mask_q <= {`SMSC_INT_W{1'b0}};
        end else if (wr_en && !reject_d) begin
            case (paddr)
                `SMSC_OFS_FIRST_ITEM: item_q[0] <= wv;
                `SMSC_OFS_SECOND_ITEM: item_q[1] <= wv;
                `SMSC_OFS_FIRST_GAIN: gain_q[0] <= wv;
                `SMSC_OFS_SECOND_GAIN: gain_q[1] <= wv;
                `SMSC_OFS_FIRST_BIAS: bias_q[0] <= wv;
                `SMSC_OFS_SECOND_BIAS: bias_q[1] <= wv;
                `SMSC_OFS_FIRST_LEVEL: level_q[0] <= wv[1:0];
                `SMSC_OFS_SECOND_LEVEL: level_q[1] <= wv[1:0];
                `SMSC_OFS_CONTACT0: csel_q[0] <= pwdata[7:0];
                `SMSC_OFS_CONTACT1: csel_q[1] <= pwdata[7:0];
                `SMSC_OFS_CONTACT2: csel_q[2] <= pwdata[7:0];
                `SMSC_OFS_INT_MASK: int_mask_q <= pwdata[`SMSC_INT_W-1:0];
                default: int_mask_q <= int_mask_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear; a new event wins over the clear.

    always @* begin
        events = {`SMSC_INT_W{1'b0}};
        events[`SMSC_INT_FAULT] = stat_q[S_FAULT] & ~stat_prev_q[S_FAULT];
        events[`SMSC_INT_MINOR] = stat_q[S_MINOR] & ~stat_prev_q[S_MINOR];
        events[`SMSC_INT_SAT_ONE] = sat & ~chan_q;
        events[`SMSC_INT_SAT_TWO] = sat & chan_q;
        events[`SMSC_INT_REJECT] = reject_d;
        int_status_d = int_status_q;
        if (wr_en && (paddr == `SMSC_OFS_INT_STATUS)) begin
            int_status_d = int_status_q & ~pwdata[`SMSC_INT_W-1:0];
        end
        int_status_d = int_status_d | events;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_q <= {`SMSC_INT_W{1'b0}};
            irq <= 1'b0;
        end else begin
            int_status_q <= int_status_d;
            irq <= |(int_status_d & int_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // APB read path; data and error are registered in the setup cycle.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= (paddr > `SMSC_OFS_OUT_TWO) || (paddr[1:0] != 2'h0);
                case (paddr)
                    `SMSC_OFS_FIRST_ITEM: prdata <= {16'h0000, item_q[0]};
                    `SMSC_OFS_FIRST_GAIN: prdata <= {16'h0000, gain_q[0]};
                    `SMSC_OFS_FIRST_BIAS: prdata <= {16'h0000, bias_q[0]};
                    `SMSC_OFS_SECOND_ITEM: prdata <= {16'h0000, item_q[1]};
                    `SMSC_OFS_SECOND_GAIN: prdata <= {16'h0000, gain_q[1]};
                    `SMSC_OFS_SECOND_BIAS: prdata <= {16'h0000, bias_q[1]};
                    `SMSC_OFS_FIRST_LEVEL: prdata <= {30'h00000000, level_q[0]};
                    `SMSC_OFS_SECOND_LEVEL: prdata <= {30'h00000000, level_q[1]};
                    `SMSC_OFS_CONTACT0: prdata <= {24'h000000, csel_q[0]};
                    `SMSC_OFS_CONTACT1: prdata <= {24'h000000, csel_q[1]};
                    `SMSC_OFS_CONTACT2: prdata <= {24'h000000, csel_q[2]};
                    `SMSC_OFS_INT_STATUS: prdata <= {27'h0000000, int_status_q};
                    `SMSC_OFS_INT_MASK: prdata <= {27'h0000000, int_mask_q};
                    `SMSC_OFS_STATE: prdata <= {5'h00, stat_q, 13'h0000, contact_out};
                    `SMSC_OFS_OUT_ONE: prdata <= {20'h00000, analog_out_one};
                    `SMSC_OFS_OUT_TWO: prdata <= {20'h00000, analog_out_two};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Contact outputs.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contact_out <= {NUM_CONTACTS{1'b0}};
        end else begin
            for (i = 0; i < NUM_CONTACTS; i = i + 1) begin
                contact_out[i] <= contact_fn(csel_q[i], stat_q);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Analog channels, time-shared scaler.

    // Sharing one multiplier halves the area; each channel refreshes every second cycle.
    smsc_scaler u_scaler (
        .item_value(monitor_value),
        .gain(gain_q[chan_q]),
        .bias(bias_q[chan_q]),
        .level(level_q[chan_q]),
        .code(scaled),
        .saturated(sat)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_q <= 1'b0;
            monitor_item <= FIRST_ITEM_RST[5:0];
            analog_out_one <= 12'h000;
            analog_out_two <= 12'h000;
            analog_out_one_range <= `SMSC_RST_LEVEL;
            analog_out_two_range <= `SMSC_RST_LEVEL;
        end else begin
            chan_q <= ~chan_q;
            monitor_item <= item_q[~chan_q][5:0];
            if (!chan_q) begin
                analog_out_one <= scaled;
                analog_out_one_range <= level_q[0];
            end else begin
                analog_out_two <= scaled;
                analog_out_two_range <= level_q[1];
            end
        end
    end

endmodule // smsc_top

// file: smsc_assertions.sv
// Purpose: Port-level checks of the status output and monitor scaler.
// Assumes: One pclk domain; presetn asynchronous and active low.
// Notes: Bound to the top module from the testbench top file.
`timescale 1ns/100ps
module smsc_assertions #(
    parameter NUM_CONTACTS = 3
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB.
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Monitor and analog outputs.
    input wire [5:0] monitor_item,
    input wire [11:0] analog_out_one,
    input wire [1:0] analog_out_one_range,
    input wire [11:0] analog_out_two
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence setup_s;
        psel && !penable;
    endsequence
    // Range and code settle together; four quiet cycles cover the alternate refresh.
    sequence one_steady_s;
        $stable(analog_out_one_range) [*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    ready_after_reset_a: assert property (presetn && $past(presetn) |-> pready)
        else $error("pready low after reset");
    unmapped_err_a: assert property (setup_s ##0 (paddr > 8'h3C) |=> pslverr)
        else $error("no error on unmapped address");
    unaligned_err_a: assert property (setup_s ##0 (paddr[1:0] != 2'h0) |=> pslverr)
        else $error("no error on unaligned address");
    mapped_ok_a: assert property (setup_s ##0 (paddr <= 8'h3C && paddr[1:0] == 2'h0)
        |=> !pslverr) else $error("error on mapped address");
    unmapped_zero_a: assert property (setup_s ##0 (!pwrite && paddr > 8'h3C)
        |=> prdata == 32'h0) else $error("unmapped read not zero");
    one_full_scale_a: assert property ($signed(analog_out_one) <= 12'sh3E8 &&
        $signed(analog_out_one) >= -12'sh3E8) else $error("channel one beyond full scale");
    two_full_scale_a: assert property ($signed(analog_out_two) <= 12'sh3E8 &&
        $signed(analog_out_two) >= -12'sh3E8) else $error("channel two beyond full scale");
    unipolar_floor_a: assert property (one_steady_s ##0 (analog_out_one_range == 2'h0)
        |-> !analog_out_one[11]) else $error("negative code in unipolar range");
    current_floor_a: assert property (one_steady_s ##0 (analog_out_one_range == 2'h2)
        |-> $signed(analog_out_one) >= 12'sh0C8) else $error("current below 4 mA");
    item_valid_a: assert property (!(monitor_item inside {6'h00, 6'h04, [6'h0A:6'h0E],
        6'h1C, 6'h22} || monitor_item > 6'h26)) else $error("invalid monitor item");
    alternate_update_a: assert property ($changed(analog_out_one)
        |-> $stable(analog_out_two)) else $error("both channels updated at once");
endmodule // smsc_assertions

// file: smsc_monitor_model.sv
// Purpose: Status monitor lookup answering the block's item requests.
// Assumes: Same-cycle combinational answer in 0.1 percent units.
// Notes: Value is (item - 16) * 100, so low items are negative and high items saturate.
`timescale 1ns/100ps
module smsc_monitor_model (
    // Lookup.
    input wire [5:0] monitor_item,
    output wire [15:0] monitor_value
);
    assign monitor_value = ({10'h000, monitor_item} - 16'h0010) * 16'h0064;
endmodule // smsc_monitor_model

// file: test_status_output_and_monitor_scaler.sv
// Purpose: Self-checking bench of the status output and monitor scaler.
// Assumes: APB master with no fixed latency; monitor model on the lookup port.
// Notes: Expected analog codes come from the scale function below.
`timescale 1ns/100ps
module test_status_output_and_monitor_scaler;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [10:0] st_in = 11'h000;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [5:0] monitor_item;
    wire [15:0] monitor_value;
    wire [2:0] contact_out;
    wire [11:0] analog_out_one, analog_out_two;
    wire [1:0] analog_out_one_range, analog_out_two_range;
    int failures = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic er;
    always #12.5 pclk = ~pclk;
    smsc_top #(.NUM_CONTACTS(3)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_src_keypad(st_in[0]), .major_fault(st_in[1]), .excluded_fault_a(st_in[2]),
        .excluded_fault_b(st_in[3]), .minor_fault(st_in[4]), .fault_reset_req(st_in[5]),
        .reverse_run_req(st_in[6]), .block_req(st_in[7]), .motor_two_sel(st_in[8]),
        .freq_output_on(st_in[9]), .drive_enable_req(st_in[10]),
        .monitor_item(monitor_item), .monitor_value(monitor_value), .contact_out(contact_out),
        .analog_out_one(analog_out_one), .analog_out_one_range(analog_out_one_range),
        .analog_out_two(analog_out_two), .analog_out_two_range(analog_out_two_range), .irq(irq));
    smsc_monitor_model mon_u (.monitor_item(monitor_item), .monitor_value(monitor_value));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic int scale(int v, int g, int b, int lv);
        int r;
        r = b + (v * (g - b)) / 1000;
        if (r > 1000) r = 1000;
        if (r < ((lv == 1) ? -1000 : 0)) r = (lv == 1) ? -1000 : 0;
        if (lv == 2) r = 200 + r - r / 5;
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values();
        logic [7:0] a[11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
            8'h20, 8'h24, 8'h28};
        logic [31:0] e[11] = '{32'h2, 32'h3E8, 32'h0, 32'h3, 32'h1F4, 32'h0, 32'h0, 32'h0,
            32'h0, 32'h1, 32'h2};
        for (int i = 0; i < 11; i++) begin
            apb(a[i], 1'b0, 32'h0);
            check("reset value", rd, e[i]);
        end
    endtask
    task automatic test_unmapped();
        apb(8'h40, 1'b0, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(8'h02, 1'b1, 32'h5);
        check("unaligned err", {31'h0, er}, 32'h1);
        apb(8'h00, 1'b0, 32'h0);
        check("item kept", rd, 32'h2);
    endtask
    task automatic test_reject();
        logic [7:0] a[15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h18};
        logic [31:0] v[15] = '{32'h4, 32'h0, 32'hA, 32'h1C, 32'h22, 32'h27, 32'h26, 32'h2,
            32'h2711, 32'h2710, 32'h3E8, 32'h44D, 32'h44C, 32'h0, 32'h3};
        logic [31:0] e[15] = '{32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h26, 32'h2,
            32'h3E8, 32'h2710, 32'h3E8, 32'h0, 32'h44C, 32'h0, 32'h0};
        for (int i = 0; i < 15; i++) begin
            apb(a[i], 1'b1, v[i]);
            apb(a[i], 1'b0, 32'h0);
            check("setting range", rd, e[i]);
        end
        apb(8'h2C, 1'b0, 32'h0);
        check("reject flag", rd & 32'h10, 32'h10);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(8'h30, 1'b1, 32'h10);
        repeat (2) @(posedge pclk);
        check("irq set", {31'h0, irq}, 32'h1);
        apb(8'h2C, 1'b1, 32'h10);
        apb(8'h2C, 1'b0, 32'h0);
        check("reject clear", rd & 32'h10, 32'h0);
        check("irq clear", {31'h0, irq}, 32'h0);
        apb(8'h30, 1'b1, 32'h0);
    endtask
    // Idle drives every other status input high so a wrong selection shows up.
    task automatic test_contacts();
        logic [7:0] fn[9] = '{8'h0A, 8'h0E, 8'h10, 8'h11, 8'h1A, 8'h1B, 8'h1C, 8'h37, 8'h38};
        int b[9] = '{0, 1, 4, 5, 6, 7, 8, 9, 10};
        logic inv;
        for (int i = 0; i < 9; i++) begin
            inv = (fn[i] == 8'h1B);
            apb(8'h20, 1'b1, {24'h0, fn[i]});
            st_in <= ~(11'h001 << b[i]);
            repeat (5) @(posedge pclk);
            check("contact idle", {31'h0, contact_out[0]}, {31'h0, inv});
            st_in <= 11'h001 << b[i];
            repeat (5) @(posedge pclk);
            check("contact active", {31'h0, contact_out[0]}, {31'h0, ~inv});
        end
        apb(8'h20, 1'b1, 32'h0E);
        st_in <= 11'h006;
        repeat (5) @(posedge pclk);
        check("excluded a", {31'h0, contact_out[0]}, 32'h0);
        st_in <= 11'h00A;
        repeat (5) @(posedge pclk);
        check("excluded b", {31'h0, contact_out[0]}, 32'h0);
        check("contacts one two", {30'h0, contact_out[2:1]}, 32'h0);
        st_in <= 11'h000;
    endtask
    task automatic test_analog();
        int it[7] = '{20, 25, 8, 20, 30, 1, 20};
        int g[7] = '{1000, 500, 1000, 1000, 1000, 1000, 0};
        int bs[7] = '{0, 100, 0, 0, 0, 0, 0};
        int lv[7] = '{0, 0, 1, 2, 0, 1, 0};
        int e;
        for (int i = 0; i < 7; i++) begin
            apb(8'h00, 1'b1, it[i]);
            apb(8'h04, 1'b1, g[i]);
            apb(8'h08, 1'b1, bs[i]);
            apb(8'h18, 1'b1, lv[i]);
            repeat (6) @(posedge pclk);
            e = scale((it[i] - 16) * 100, g[i], bs[i], lv[i]);
            check("analog one", {20'h0, analog_out_one}, e & 32'hFFF);
            check("range one", {30'h0, analog_out_one_range}, lv[i]);
            apb(8'h38, 1'b0, 32'h0);
            check("analog reg", rd, e & 32'hFFF);
        end
        apb(8'h1C, 1'b1, 32'h1);
        repeat (6) @(posedge pclk);
        check("analog two", {20'h0, analog_out_two}, scale(-1300, 500, 0, 1) & 32'hFFF);
        apb(8'h0C, 1'b1, 32'h1E);
        repeat (6) @(posedge pclk);
        check("analog two", {20'h0, analog_out_two}, scale(1400, 500, 0, 1) & 32'hFFF);
        check("range two", {30'h0, analog_out_two_range}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_reset_values();
        test_unmapped();
        test_reject();
        test_contacts();
        test_analog();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        final_report();
    end
endmodule // test_status_output_and_monitor_scaler
bind smsc_top smsc_assertions #(.NUM_CONTACTS(NUM_CONTACTS)) chk_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .monitor_item(monitor_item), .analog_out_one(analog_out_one),
    .analog_out_one_range(analog_out_one_range), .analog_out_two(analog_out_two));
